// *** hdl/dgl_frame_link.sv ***
module dgl_frame_link #(
   parameter int HALF_CYC    = dgl_pkg::HALF_BIT_CYC,
   parameter int FORCE_CYC   = dgl_pkg::CORRUPT_CYC,
   parameter int TICK_CYC    = dgl_pkg::US_CYC,
   parameter bit MULTI_UNIT  = 1'b1
) (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic               edge_capture_input,
   input  wire logic               frame_ack,
   input  wire logic               tx_req,
   input  wire logic [7:0]         tx_data,
   input  wire logic               tx_corrupt,
   output logic                    frame_valid,
   output dgl_pkg::dgl_frame_t     frame,
   output logic                    tx_busy,
   output logic                    tx_done,
   output logic                    bus_transmit_pin
);
   import dgl_pkg::*;

   localparam int EW = $bits(dgl_evt_t);

   if (HALF_CYC < 2 || FORCE_CYC < 1 || TICK_CYC < 1 || TICK_CYC > 16) begin : g_chk
      $error("Timing counts are too small.");
   end

   logic             in_s1;
   logic             in_s2;
   logic [3:0]       us_cnt;
   logic             us_tick;
   logic [9:0]       ms_cnt;
   logic             ms_tick;
   logic             rec_level;
   logic [DUR_W-1:0] dur;
   logic [6:0]       rx_blanking_timer;
   logic             rx_active;
   logic             evt_valid;
   dgl_evt_t         evt;
   logic             evt_ready;
   logic             q_valid;
   logic             q_ready;
   logic [EW-1:0]    q_raw;
   dgl_evt_t         q;
   logic             dec_run;
   logic             dec_mid;
   logic             dec_first;
   logic             dec_err;
   logic [5:0]       nbits;
   logic [31:0]      shreg;
   logic             frame_end;
   logic [7:0]       since_ms;
   logic [7:0]       prev_len;
   logic [31:0]      prev_data;
   logic             win_open;
   logic             tx_pend;
   logic [7:0]       tx_byte;
   logic             tx_bad;
   logic             tx_start;
   logic             snd_done;
   logic [1:0]       cls;
   logic             next_mid;
   logic             next_err;
   logic [7:0]       next_len;

   // Interval class: 1 for a half bit, 2 for a full bit, 0 for neither.
   function automatic logic [1:0] classify(input logic [DUR_W-1:0] d);
      if (d >= DUR_W'(HALF_MIN_US) && d <= DUR_W'(HALF_MAX_US)) begin
         return 2'h1;
      end else if (d >= DUR_W'(FULL_MIN_US) && d <= DUR_W'(FULL_MAX_US)) begin
         return 2'h2;
      end
      return 2'h0;
   endfunction

   // Two-stage synchroniser for the bus level.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         in_s1 <= IDLE_LEVEL;
         in_s2 <= IDLE_LEVEL;
      end else begin
         in_s1 <= edge_capture_input;
         in_s2 <= in_s1;
      end
   end

   // Microsecond and millisecond ticks; TICK_CYC clocks make one microsecond.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         us_cnt  <= '0;
         us_tick <= 1'b0;
         ms_cnt  <= '0;
         ms_tick <= 1'b0;
      end else begin
         us_tick <= (us_cnt == 4'(TICK_CYC - 1));
         us_cnt  <= (us_cnt == 4'(TICK_CYC - 1)) ? '0 : us_cnt + 1'b1;
         ms_tick <= 1'b0;
         if (us_tick) begin
            ms_tick <= (ms_cnt == 10'(MS_US - 1));
            ms_cnt  <= (ms_cnt == 10'(MS_US - 1)) ? '0 : ms_cnt + 1'b1;
         end
      end
   end

   // Edge capture with blanking, stop detection and a pending event slot.
   // A full buffer stalls capture; the level change is then taken later.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rec_level         <= IDLE_LEVEL;
         dur               <= '0;
         rx_blanking_timer <= '0;
         rx_active         <= 1'b0;
         evt_valid         <= 1'b0;
         evt               <= '0;
      end else begin
         if (us_tick && dur != '1) dur <= dur + 1'b1;
         if (us_tick && rx_blanking_timer != '0) begin
            rx_blanking_timer <= rx_blanking_timer - 1'b1;
         end
         if (evt_valid && evt_ready) evt_valid <= 1'b0;
         if (tx_busy) begin
            // Own reply on the bus is not captured.
            rec_level <= in_s2;
            dur       <= '0;
            rx_active <= 1'b0;
         end else if (!evt_valid || evt_ready) begin
            if (rx_blanking_timer == '0 && in_s2 != rec_level) begin
               evt_valid         <= 1'b1;
               evt               <= '{stop: 1'b0, level: in_s2, dur: dur};
               rec_level         <= in_s2;
               dur               <= '0;
               rx_blanking_timer <= 7'(BLANK_US);
               rx_active         <= 1'b1;
            end else if (rx_active && rec_level && dur >= DUR_W'(STOP_US)) begin
               evt_valid <= 1'b1;
               evt       <= '{stop: 1'b1, level: 1'b1, dur: dur};
               rx_active <= 1'b0;
            end
         end
      end
   end

   // Event ring between capture and decoding.
   dgl_fifo #(
      .WIDTH (EW),
      .DEPTH (EVT_DEPTH)
   ) u_ring (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (evt_valid),
      .in_ready  (evt_ready),
      .in_data   (evt),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_raw)
   );

   assign q = dgl_evt_t'(q_raw);
   // The decoder waits only while a finished result is still unread.
   assign q_ready = !frame_valid;

   // Manchester decode step for the event at the buffer head.
   always_comb begin
      cls      = classify(q.dur);
      next_mid = dec_mid;
      next_err = dec_err;
      if (cls == 2'h1) begin
         next_mid = !dec_mid;
      end else if (cls == 2'h2) begin
         next_err = dec_err || !dec_mid;
         next_mid = 1'b1;
      end else begin
         next_err = 1'b1;
      end
      next_len = (dec_err || nbits == '0) ? LEN_ERROR : {2'b00, nbits};
   end

   // Decoder state and received data.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         dec_run   <= 1'b0;
         dec_mid   <= 1'b0;
         dec_first <= 1'b0;
         dec_err   <= 1'b0;
         nbits     <= '0;
         shreg     <= '0;
         frame_end <= 1'b0;
      end else begin
         frame_end <= 1'b0;
         if (q_valid && q_ready) begin
            if (q.stop) begin
               dec_run   <= 1'b0;
               frame_end <= dec_run;
            end else if (!dec_run) begin
               if (!q.level) begin
                  dec_run   <= 1'b1;
                  dec_mid   <= 1'b0;
                  dec_first <= 1'b1;
                  dec_err   <= 1'b0;
                  nbits     <= '0;
                  shreg     <= '0;
               end
            end else begin
               dec_mid <= next_mid;
               dec_err <= next_err;
               if (next_mid && !next_err) begin
                  if (dec_first) begin
                     dec_first <= 1'b0;
                     dec_err   <= !q.level;
                  end else if (nbits == 6'(MAX_BITS)) begin
                     dec_err <= 1'b1;
                  end else begin
                     shreg <= {shreg[30:0], q.level};
                     nbits <= nbits + 1'b1;
                  end
               end
            end
         end
      end
   end

   // Frame result; the acknowledge empties it so the length reads zero.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         frame_valid <= 1'b0;
         frame       <= '{len: LEN_NONE, data: '0, twice: 1'b0};
         prev_len    <= LEN_NONE;
         prev_data   <= '0;
      end else if (frame_end) begin
         frame_valid <= 1'b1;
         frame.len   <= next_len;
         frame.data  <= shreg;
         frame.twice <= next_len != LEN_ERROR && next_len == prev_len
                        && shreg == prev_data && since_ms <= 8'(TWICE_MS);
         prev_len    <= next_len;
         prev_data   <= shreg;
      end else if (frame_ack) begin
         frame_valid <= 1'b0;
         frame.len   <= LEN_NONE;
      end
   end

   // Coarse time since the last forward frame, saturating.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         since_ms <= '1;
      end else if (frame_end) begin
         since_ms <= '0;
      end else if (ms_tick && since_ms != '1) begin
         since_ms <= since_ms + 1'b1;
      end
   end

   // Reply window: opens after a good frame, closes when it runs out.
   // It shuts at the last whole tick, so a late launch still lands before the upper limit.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         win_open <= 1'b0;
      end else if (frame_end) begin
         win_open <= (next_len != LEN_ERROR);
      end else if (since_ms >= 8'(SETTLE_LAST_MS) || (tx_req && !tx_busy)) begin
         win_open <= 1'b0;
      end
   end

   // Reply request, settling wait and launch.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_pend  <= 1'b0;
         tx_byte  <= '0;
         tx_bad   <= 1'b0;
         tx_start <= 1'b0;
         tx_busy  <= 1'b0;
         tx_done  <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         tx_done  <= snd_done;
         if (tx_req && !tx_busy && win_open) begin
            tx_pend <= 1'b1;
            tx_busy <= 1'b1;
            tx_byte <= tx_data;
            tx_bad  <= tx_corrupt && MULTI_UNIT;
         end else if (tx_pend && since_ms >= 8'(SETTLE_TICKS)) begin
            tx_pend  <= 1'b0;
            tx_start <= 1'b1;
         end
         if (snd_done) tx_busy <= 1'b0;
      end
   end

   dgl_reply_sender #(
      .HALF_CYC  (HALF_CYC),
      .FORCE_CYC (FORCE_CYC)
   ) reply_frame_sender (
      .clk     (clk),
      .rstn    (rstn),
      .start   (tx_start),
      .data    (tx_byte),
      .corrupt (tx_bad),
      .done    (snd_done),
      .pin     (bus_transmit_pin)
   );
endmodule

// *** hdl/dgl_pkg.sv ***
package dgl_pkg;
   // Clock and time base.
   localparam int CLK_PERIOD_NS = 100;
   localparam int US_NS         = 1000;
   localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
   localparam int MS_US         = 1000;

   // Half-bit length, then the receive limits in microseconds.
   localparam int HALF_BIT_NS  = 416_700;
   localparam int HALF_BIT_CYC = HALF_BIT_NS / CLK_PERIOD_NS;
   localparam int HALF_MIN_US  = 333;
   localparam int HALF_MAX_US  = 500;
   localparam int FULL_MIN_US  = 667;
   localparam int FULL_MAX_US  = 1000;
   localparam int BLANK_US     = 100;
   localparam int STOP_US      = 1900;

   // Transmit timing.
   localparam int TX_TIMER_US    = 1458;
   localparam int CORRUPT_CYC    = TX_TIMER_US * US_NS / CLK_PERIOD_NS;
   localparam int SETTLE_MIN_US  = 5500;
   localparam int SETTLE_MAX_US  = 10500;
   localparam int SETTLE_TICKS   = (SETTLE_MIN_US + MS_US - 1) / MS_US + 1;
   localparam int SETTLE_LAST_MS = SETTLE_MAX_US / MS_US;
   localparam logic [7:0] CORRUPT_DATA = 8'h00;

   // Sizes and reset values.
   localparam int EVT_DEPTH  = 16;
   localparam int DUR_W      = 12;
   localparam int MAX_BITS   = 32;
   localparam int TWICE_MS   = 100;
   localparam logic [7:0] LEN_ERROR = 8'hff;
   localparam logic [7:0] LEN_NONE  = 8'h00;
   localparam logic       IDLE_LEVEL = 1'b1;

   // One captured bus event: an edge with the level after it, or a stop.
   typedef struct packed {
      logic             stop;
      logic             level;
      logic [DUR_W-1:0] dur;
   } dgl_evt_t;

   // Result of one received forward frame.
   typedef struct packed {
      logic [7:0]  len;
      logic [31:0] data;
      logic        twice;
   } dgl_frame_t;

   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } dgl_tx_state_t;
endpackage

// *** hdl/dgl_fifo.sv ***
module dgl_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("Depth must be a power of two of at least two.");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage array, written on push.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill level.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end
endmodule

// *** hdl/dgl_reply_sender.sv ***
module dgl_reply_sender
   import dgl_pkg::*;
#(
   parameter int HALF_CYC  = HALF_BIT_CYC,
   parameter int FORCE_CYC = CORRUPT_CYC
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       start,
   input  wire logic [7:0] data,
   input  wire logic       corrupt,
   output logic            done,
   output logic            pin
);
   if (HALF_CYC < 2 || FORCE_CYC < 1 || HALF_CYC > 65536 || FORCE_CYC > 65535) begin : g_chk
      $error("Sender timing counts are too small.");
   end

   dgl_tx_state_t state;
   logic [8:0]    frame;
   logic [4:0]    half_idx;
   logic [15:0]   half_cnt;
   logic [15:0]   force_cnt;
   logic          bit_now;
   logic          next_pin;

   // Level of the current half bit; the second half carries the bit value.
   always_comb begin
      bit_now  = frame[4'(8 - half_idx[4:1])];
      next_pin = half_idx[0] ? bit_now : !bit_now;
   end

   // Manchester start bit plus eight data bits, most significant first.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state    <= TX_IDLE;
         frame    <= '0;
         half_idx <= '0;
         half_cnt <= '0;
         done     <= 1'b0;
         pin      <= IDLE_LEVEL;
      end else begin
         done <= 1'b0;
         case (state)
            TX_IDLE: begin
               pin <= IDLE_LEVEL;
               if (start) begin
                  frame    <= {1'b1, corrupt ? CORRUPT_DATA : data};
                  half_idx <= '0;
                  half_cnt <= '0;
                  state    <= TX_SEND;
               end
            end
            TX_SEND: begin
               pin <= next_pin && (force_cnt == '0);
               if (half_cnt == 16'(HALF_CYC - 1)) begin
                  half_cnt <= '0;
                  if (half_idx == 5'd17) begin
                     state <= TX_IDLE;
                     done  <= 1'b1;
                  end else begin
                     half_idx <= half_idx + 1'b1;
                  end
               end else begin
                  half_cnt <= half_cnt + 1'b1;
               end
            end
            default: state <= TX_IDLE;
         endcase
      end
   end

   // Interval timer that holds the bus low from the first half bit on.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         force_cnt <= '0;
      end else if (start && state == TX_IDLE && corrupt) begin
         force_cnt <= 16'(FORCE_CYC);
      end else if (force_cnt != '0) begin
         force_cnt <= force_cnt - 1'b1;
      end
   end
endmodule

// *** bench/dgl_frame_link_monitor.sv ***
module dgl_frame_link_monitor
   import dgl_pkg::*;
#(
   parameter int HALF_CYC   = 20,
   parameter int FORCE_CYC  = 70,
   parameter int TICK_CYC   = US_CYC,
   parameter bit MULTI_UNIT = 1'b1
) (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       edge_capture_input,
   input wire logic       frame_ack,
   input wire logic       tx_req,
   input wire logic [7:0] tx_data,
   input wire logic       tx_corrupt,
   input wire logic       frame_valid,
   input wire dgl_frame_t frame,
   input wire logic       tx_busy,
   input wire logic       tx_done,
   input wire logic       bus_transmit_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [16:0] since_end;
   logic [15:0] low_run;
   logic [15:0] tx_cnt;
   logic        sent;
   logic        corr;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // Cycles since the latest frame result appeared, saturating so it never wraps.
   always_ff @(posedge clk) begin
      if (!rstn || $rose(frame_valid)) since_end <= '0;
      else if (since_end != '1) since_end <= since_end + 1'b1;
   end

   // Length of the current low run on the transmit pin.
   always_ff @(posedge clk) begin
      if (!rstn || bus_transmit_pin) low_run <= '0;
      else low_run <= low_run + 1'b1;
   end

   // Reply progress: cycles since the first low, and whether it has begun.
   always_ff @(posedge clk) begin
      if (!rstn || !tx_busy) tx_cnt <= '0;
      else if (sent || !bus_transmit_pin) tx_cnt <= tx_cnt + 1'b1;
   end
   always_ff @(posedge clk) begin
      if (!rstn || !tx_busy) sent <= 1'b0;
      else if (!bus_transmit_pin) sent <= 1'b1;
   end

   // Remembers whether the accepted reply asked for corruption.
   always_ff @(posedge clk) begin
      if (!rstn) corr <= 1'b0;
      else if ($rose(tx_busy)) corr <= $past(tx_corrupt) && MULTI_UNIT;
   end

   sequence s_accept;
      tx_req && !tx_busy ##1 tx_busy;
   endsequence
   sequence s_reply_end;
      tx_busy ##1 !tx_busy && tx_done;
   endsequence

   a_ack_clears_result: assert property (frame_valid && frame_ack |=>
      !frame_valid && frame.len == LEN_NONE) else $error("result not cleared by ack");
   a_result_holds: assert property (frame_valid && !frame_ack |=>
      frame_valid && $stable(frame)) else $error("result changed before ack");
   a_len_legal: assert property (frame_valid |-> frame.len == LEN_ERROR ||
      (frame.len != LEN_NONE && frame.len <= 8'(MAX_BITS))) else $error("bad frame length");
   a_settle_window: assert property (tx_busy && !sent && !bus_transmit_pin |->
      since_end >= 5500 * TICK_CYC && since_end <= 10500 * TICK_CYC)
      else $error("reply outside settle window");
   a_accept_quiet: assert property (s_accept |-> bus_transmit_pin [*4])
      else $error("reply began at once");
   a_force_low: assert property ($rose(bus_transmit_pin) && tx_busy && corr &&
      tx_cnt == low_run |-> low_run >= FORCE_CYC && low_run <= FORCE_CYC + HALF_CYC)
      else $error("forced low has wrong length");
   a_corrupt_zero: assert property ($rose(bus_transmit_pin) && tx_busy && corr &&
      tx_cnt != low_run |-> low_run == HALF_CYC) else $error("corrupt data not zero");
   a_reply_length: assert property (tx_done |-> tx_cnt >= 18 * HALF_CYC &&
      tx_cnt <= 18 * HALF_CYC + 3) else $error("reply length wrong");
   a_done_once: assert property (s_reply_end |=> !tx_done && !tx_busy)
      else $error("done not a single pulse");
   a_idle_high: assert property (!tx_busy |-> bus_transmit_pin)
      else $error("bus pulled low while idle");
endmodule

bind dgl_frame_link dgl_frame_link_monitor #(
   .HALF_CYC(HALF_CYC), .FORCE_CYC(FORCE_CYC), .TICK_CYC(TICK_CYC), .MULTI_UNIT(MULTI_UNIT)
) mon (
   .clk(clk), .rstn(rstn), .edge_capture_input(edge_capture_input),
   .frame_ack(frame_ack), .tx_req(tx_req), .tx_data(tx_data), .tx_corrupt(tx_corrupt),
   .frame_valid(frame_valid), .frame(frame), .tx_busy(tx_busy), .tx_done(tx_done),
   .bus_transmit_pin(bus_transmit_pin)
);

// *** bench/dgl_bus_ctrl_model.sv ***
module dgl_bus_ctrl_model (
   input  wire logic clk,
   input  wire logic dev_pin,
   output logic      bus
);
   timeunit 1ns;
   timeprecision 1ns;

   logic drv = 1'b1;

   // Open-drain bus with pull-up: low while either side pulls it low.
   assign bus = drv & dev_pin;

   // Holds the bus at one level for a number of clock cycles.
   task automatic hold(input logic lvl, input int n);
      drv = lvl;
      repeat (n) @(negedge clk);
   endtask

   // Sends a forward frame MSB first, with a short spike inside the start bit.
   // The spike scales with the half bit so it always ends inside the blanking time.
   task automatic send_frame(input logic [31:0] bits, input int n, input int half);
      hold(1'b0, half / 14);
      hold(1'b1, half / 14);
      hold(1'b0, half - 2 * (half / 14));
      hold(1'b1, half);
      for (int i = n - 1; i >= 0; i--) begin
         hold(~bits[i], half);
         hold(bits[i], half);
      end
      drv = 1'b1;
   endtask
endmodule

// *** bench/tb.sv ***
module tb
   import dgl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // Short sender timing, and four clocks to the microsecond so receive waits stay brief.
   localparam int HALF  = 20;
   localparam int FORCE = 70;
   localparam int TICK  = 4;
   localparam int HBIT  = HALF_BIT_NS * TICK / US_NS;

   logic       clk        = 1'b0;
   logic       rstn       = 1'b0;
   logic       frame_ack  = 1'b0;
   logic       tx_req     = 1'b0;
   logic [7:0] tx_data    = 8'h00;
   logic       tx_corrupt = 1'b0;
   logic       bus;
   logic       frame_valid;
   logic       tx_busy;
   logic       tx_done;
   logic       pin;
   dgl_frame_t frame;
   int         fail_count  = 0;
   int         check_count = 0;
   int         cyc         = 0;
   int         t_end       = 0;
   int         done_cnt    = 0;

   // Clock and a free cycle counter for timing checks.
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   // Counts reply-done pulses, sampled away from the edge that launches them.
   always @(negedge clk) done_cnt <= done_cnt + int'(tx_done);

   dgl_frame_link #(
      .HALF_CYC(HALF), .FORCE_CYC(FORCE), .TICK_CYC(TICK), .MULTI_UNIT(1'b1)
   ) dut (
      .clk(clk), .rstn(rstn), .edge_capture_input(bus), .frame_ack(frame_ack),
      .tx_req(tx_req), .tx_data(tx_data), .tx_corrupt(tx_corrupt),
      .frame_valid(frame_valid), .frame(frame), .tx_busy(tx_busy), .tx_done(tx_done),
      .bus_transmit_pin(pin)
   );

   dgl_bus_ctrl_model bus_ctrl (.clk(clk), .dev_pin(pin), .bus(bus));

   // Compares a seen value with the expected one and counts both outcomes.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Waits for a frame result; lead is how long the bus has already been high.
   task automatic wait_valid(input int lead);
      int n;
      n = 0;
      while (frame_valid !== 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      t_end = cyc;
      n = (n + lead) / TICK;
      check(32'(frame_valid), 32'h0000_0001, "frame result");
      check(32'(n >= 1400 && n <= 2400), 32'h0000_0001, "stop time");
   endtask

   // Acknowledges the result and expects it to clear.
   task automatic ack;
      frame_ack = 1'b1;
      @(negedge clk);
      frame_ack = 1'b0;
      @(negedge clk);
      check(32'(frame_valid), 32'h0000_0000, "valid after ack");
      check(32'(frame.len), 32'h0000_0000, "len after ack");
   endtask

   // Reset values, and a reply request with no forward frame is ignored.
   task automatic test_reset;
      check(32'(frame_valid), 32'h0000_0000, "valid at reset");
      check(32'(frame.len), 32'h0000_0000, "len at reset");
      check(32'(pin), 32'h0000_0001, "pin at reset");
      tx_req = 1'b1;
      @(negedge clk);
      tx_req = 1'b0;
      repeat (5) @(negedge clk);
      check(32'(tx_busy), 32'h0000_0000, "request without frame");
      $display("test_reset done");
   endtask

   // A low pulse that fits neither a half nor a full bit gives an error result.
   task automatic test_error_frame;
      bus_ctrl.hold(1'b0, 600 * TICK);
      bus_ctrl.hold(1'b1, 1);
      wait_valid(1);
      check(32'(frame.len), 32'h0000_00ff, "error len");
      ack();
      $display("test_error_frame done");
   endtask

   // A two-bit frame with a noise spike in the start bit decodes cleanly; sent twice,
   // the repeat is flagged as a send-twice frame.
   task automatic test_good_frame;
      for (int k = 0; k < 2; k++) begin
         bus_ctrl.send_frame(32'h0000_0001, 2, HBIT);
         wait_valid(HBIT);
         check(32'(frame.len), 32'h0000_0002, "good len");
         check(frame.data, 32'h0000_0001, "good data");
         check(32'(frame.twice), 32'(k), "twice flag");
         ack();
      end
      $display("test_good_frame done");
   endtask

   // Corrupted reply: settle delay, forced low, zero data, one reply only.
   task automatic test_corrupt_reply;
      int n;
      tx_data = 8'ha5;
      tx_corrupt = 1'b1;
      tx_req = 1'b1;
      @(negedge clk);
      check(32'(tx_busy), 32'h0000_0001, "reply accepted");
      // The request stays up one more edge; being busy, it must be ignored.
      @(negedge clk);
      tx_req = 1'b0;
      n = 0;
      while (pin !== 1'b0 && n < 60000) begin
         @(negedge clk);
         n++;
      end
      n = (cyc - t_end) / TICK;
      check(32'(n >= 5500 && n <= 10500), 32'h0000_0001, "settle");
      repeat (HALF / 2) @(negedge clk);
      for (int h = 0; h < 18; h++) begin
         check(32'(pin), 32'(h >= 4 && h[0] == 1'b0), "reply half");
         repeat (HALF) @(negedge clk);
      end
      check(32'(pin), 32'h0000_0001, "released after reply");
      check(32'(tx_busy), 32'h0000_0000, "busy after reply");
      n = 0;
      repeat (200) begin
         @(negedge clk);
         n += int'(pin !== 1'b1);
      end
      check(32'(n), 32'h0000_0000, "no second reply");
      check(32'(done_cnt), 32'h0000_0001, "done pulses");
      $display("test_corrupt_reply done");
   endtask

   // Main sequence: reset for 16 cycles, then the tests.
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      test_reset();
      test_error_frame();
      test_good_frame();
      test_corrupt_reply();
      report_and_stop();
   end

   // Watchdog sized well beyond the expected run of about 69000 cycles.
   initial begin
      repeat (100000) @(negedge clk);
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule
